//--- design/fdg_flash_gpio_top.sv
// Purpose: TX pin GPIO/interrupt control and last flash level capture
// Assumes: Register strobes come from the serial interface decoder
// Notes: Pins are split into input, output and active-low enable
`timescale 1ns/100ps
`default_nettype none
`include "fdg_consts.svh"

module fdg_flash_gpio_top #(
  parameter int TRIP_CYC = `FDG_TRIP_CYC,
  parameter int FLASH_CYC = `FDG_FLASH_CYC
) (
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  output logic O_REG_RVALID,
  input wire logic I_PIN_A_IN,
  output logic O_PIN_A_OUT,
  output logic O_PIN_A_OE_N,
  input wire logic I_PIN_B_IN,
  output logic O_PIN_B_OUT,
  output logic O_PIN_B_OE_N,
  input wire logic I_INT_REQ,
  input wire logic I_HW_TORCH_EN,
  input wire logic I_FLASH_DONE,
  output logic O_TX1_LVL,
  output logic O_TORCH_LVL,
  output logic O_TX2_LVL,
  output logic O_TORCH_BIT_CLR,
  input wire logic I_NTC_EN,
  input wire logic I_VIN_MON_EN,
  input wire logic I_SUPPLY_FLASH_THRESHOLD_EN,
  input wire logic I_NTC_BELOW,
  input wire logic I_VIN_BELOW,
  input wire logic I_SUPPLY_FLASH_THRESHOLD_BELOW,
  input wire logic [3:0] I_LED_A_CODE,
  input wire logic [3:0] I_LED_B_CODE,
  output fdg_pkg::fdg_evt_t O_FLAG_SET
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [4:0] sync_lvl;

  fdg_sync #(.W(5)) u_sync (
    .i_clk(I_CORE_CLK),
    .i_rst_n(rst_n),
    .i_async({I_SUPPLY_FLASH_THRESHOLD_BELOW, I_VIN_BELOW, I_NTC_BELOW, I_PIN_B_IN, I_PIN_A_IN}),
    .o_sync(sync_lvl)
  );

  wire pin_a_s = sync_lvl[0];
  wire pin_b_s = sync_lvl[1];

  // ----------------------------------------
  // Setup sequence
  // ----------------------------------------
  function automatic fdg_pkg::fdg_setup_t setup_next(
    input fdg_pkg::fdg_setup_t st,
    input logic ctrl,
    input logic same
  );
    case (st)
      fdg_pkg::FDG_ST_FREE: begin
        setup_next = ctrl ? fdg_pkg::FDG_ST_HALF : fdg_pkg::FDG_ST_FREE;
      end
      fdg_pkg::FDG_ST_HALF: begin
        setup_next = !ctrl ? fdg_pkg::FDG_ST_FREE :
                     (same ? fdg_pkg::FDG_ST_ARMED : fdg_pkg::FDG_ST_HALF);
      end
      fdg_pkg::FDG_ST_ARMED: begin
        setup_next = ctrl ? fdg_pkg::FDG_ST_ARMED : fdg_pkg::FDG_ST_FREE;
      end
      default: begin
        setup_next = fdg_pkg::FDG_ST_FREE;
      end
    endcase
  endfunction

  fdg_pkg::fdg_pin_func_t gpio_q;
  fdg_pkg::fdg_pin_func_t gpio_d;
  fdg_pkg::fdg_setup_t a_st_q;
  fdg_pkg::fdg_setup_t b_st_q;
  logic [7:0] last_wr_q;
  fdg_pkg::fdg_code_t cap_q;

  wire wr_hit = I_REG_WR && (I_REG_ADDR == `FDG_OFS_PIN_FUNC);
  wire same_wr = (I_REG_WDATA == last_wr_q);
  wire w_a_ctrl = I_REG_WDATA[`FDG_B_A_CTRL];
  wire w_a_dir = I_REG_WDATA[`FDG_B_A_DIR];
  wire w_b_ctrl = I_REG_WDATA[`FDG_B_B_CTRL];
  wire w_b_dir = I_REG_WDATA[`FDG_B_B_DIR];

  // Input pins store the pin level at each write, outputs keep written data
  assign gpio_d.spare = 1'b0;
  assign gpio_d.int_en = I_REG_WDATA[`FDG_B_INT_EN];
  assign gpio_d.b_ctrl = w_b_ctrl;
  assign gpio_d.b_dir = w_b_dir;
  assign gpio_d.b_data = (w_b_ctrl && !w_b_dir) ? pin_b_s : I_REG_WDATA[`FDG_B_B_DATA];
  assign gpio_d.a_ctrl = w_a_ctrl;
  assign gpio_d.a_dir = w_a_dir;
  assign gpio_d.a_data = (w_a_ctrl && !w_a_dir) ? pin_a_s : I_REG_WDATA[`FDG_B_A_DATA];

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      gpio_q <= `FDG_PIN_FUNC_RST;
      last_wr_q <= 8'h00;
      a_st_q <= fdg_pkg::FDG_ST_FREE;
      b_st_q <= fdg_pkg::FDG_ST_FREE;
    end else if (wr_hit) begin
      gpio_q <= gpio_d;
      last_wr_q <= I_REG_WDATA;
      a_st_q <= setup_next(a_st_q, w_a_ctrl, same_wr);
      b_st_q <= setup_next(b_st_q, w_b_ctrl, same_wr);
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  wire a_drv = (a_st_q == fdg_pkg::FDG_ST_ARMED) && gpio_q.a_ctrl && gpio_q.a_dir;
  wire b_drv = (b_st_q == fdg_pkg::FDG_ST_ARMED) && gpio_q.b_ctrl && gpio_q.b_dir;
  wire b_int = b_drv && gpio_q.int_en;
  wire b_out_d = b_int ? 1'b0 : gpio_q.b_data;
  wire b_oe_n_d = b_int ? !I_INT_REQ : !b_drv;
  wire torch_sel = !gpio_q.a_ctrl && I_HW_TORCH_EN;

  logic pin_a_out_q;
  logic pin_a_oe_n_q;
  logic pin_b_out_q;
  logic pin_b_oe_n_q;
  logic tx1_q;
  logic torch_q;
  logic tx2_q;
  logic torch_clr_q;

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_out_q <= 1'b0;
      pin_a_oe_n_q <= 1'b1;
      pin_b_out_q <= 1'b0;
      pin_b_oe_n_q <= 1'b1;
      tx1_q <= 1'b0;
      torch_q <= 1'b0;
      tx2_q <= 1'b0;
      torch_clr_q <= 1'b0;
    end else begin
      pin_a_out_q <= gpio_q.a_data;
      pin_a_oe_n_q <= !a_drv;
      pin_b_out_q <= b_out_d;
      pin_b_oe_n_q <= b_oe_n_d;
      tx1_q <= !gpio_q.a_ctrl && !I_HW_TORCH_EN && pin_a_s;
      torch_q <= torch_sel && pin_a_s;
      tx2_q <= !gpio_q.b_ctrl && pin_b_s;
      torch_clr_q <= I_FLASH_DONE && I_HW_TORCH_EN;
    end
  end

  // ----------------------------------------
  // Event qualification and capture
  // ----------------------------------------
  logic [2:0] qual;
  logic [2:0] fire;
  fdg_pkg::fdg_evt_t flag_q;

  assign qual[0] = sync_lvl[2] && I_NTC_EN;
  assign qual[1] = sync_lvl[3] && I_VIN_MON_EN;
  assign qual[2] = sync_lvl[4] && I_SUPPLY_FLASH_THRESHOLD_EN;

  fdg_dly #(.N(TRIP_CYC)) u_dly_ntc (
    .i_clk(I_CORE_CLK),
    .i_rst_n(rst_n),
    .i_lvl(qual[0]),
    .o_pulse(fire[0])
  );

  fdg_dly #(.N(TRIP_CYC)) u_dly_vin (
    .i_clk(I_CORE_CLK),
    .i_rst_n(rst_n),
    .i_lvl(qual[1]),
    .o_pulse(fire[1])
  );

  fdg_dly #(.N(FLASH_CYC)) u_dly_vinf (
    .i_clk(I_CORE_CLK),
    .i_rst_n(rst_n),
    .i_lvl(qual[2]),
    .o_pulse(fire[2])
  );

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 3'b000;
      cap_q <= `FDG_CAP_RST;
    end else begin
      flag_q <= fire;
      if (|fire) begin
        cap_q <= {I_LED_B_CODE, I_LED_A_CODE};
      end
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  wire [7:0] rd_mux = (I_REG_ADDR == `FDG_OFS_PIN_FUNC) ? gpio_q :
                      (I_REG_ADDR == `FDG_OFS_CAP_LVL) ? cap_q : 8'h00;
  logic [7:0] rdata_q;
  logic rvalid_q;

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= I_REG_RD;
      if (I_REG_RD) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign O_REG_RDATA = rdata_q;
  assign O_REG_RVALID = rvalid_q;
  assign O_PIN_A_OUT = pin_a_out_q;
  assign O_PIN_A_OE_N = pin_a_oe_n_q;
  assign O_PIN_B_OUT = pin_b_out_q;
  assign O_PIN_B_OE_N = pin_b_oe_n_q;
  assign O_TX1_LVL = tx1_q;
  assign O_TORCH_LVL = torch_q;
  assign O_TX2_LVL = tx2_q;
  assign O_TORCH_BIT_CLR = torch_clr_q;
  assign O_FLAG_SET = flag_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [15:0] hold_q [3];

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        hold_q[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        hold_q[i] <= !qual[i] ? 16'h0000 : (&hold_q[i] ? hold_q[i] : hold_q[i] + 16'h0001);
      end
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!rst_n);

  property p_a_drive;
    a_drv |=> !O_PIN_A_OE_N && (O_PIN_A_OUT == $past(gpio_q.a_data));
  endproperty
  a_a_drive: assert property (p_a_drive) else $error("Pin A not driven");
  property p_single_setup;
    (wr_hit && a_st_q == fdg_pkg::FDG_ST_FREE) |=> a_st_q != fdg_pkg::FDG_ST_ARMED ##1 O_PIN_A_OE_N;
  endproperty
  a_single_setup: assert property (p_single_setup) else $error("Single write armed pin");
  property p_armed_update;
    (wr_hit && b_st_q == fdg_pkg::FDG_ST_ARMED && w_b_ctrl && w_b_dir && !gpio_d.int_en)
      |=> ##1 (O_PIN_B_OUT == $past(I_REG_WDATA[`FDG_B_B_DATA], 2)) && !O_PIN_B_OE_N;
  endproperty
  a_armed_update: assert property (p_armed_update) else $error("Armed write not applied");
  property p_in_hold;
    !wr_hit |=> $stable(gpio_q);
  endproperty
  a_in_hold: assert property (p_in_hold) else $error("Register changed without write");
  property p_int_out;
    (b_int && I_INT_REQ) |=> !O_PIN_B_OE_N && !O_PIN_B_OUT;
  endproperty
  a_int_out: assert property (p_int_out) else $error("Interrupt not driven");
  property p_cap_flag;
    (|O_FLAG_SET) |-> cap_q == $past({I_LED_B_CODE, I_LED_A_CODE});
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("Capture not with flag");
  property p_cap_still;
    !(|O_FLAG_SET) |-> $stable(cap_q);
  endproperty
  a_cap_still: assert property (p_cap_still) else $error("Capture changed without event");
  property p_ntc_wait;
    O_FLAG_SET.ntc |-> $past(hold_q[0], 2) == 16'(TRIP_CYC - 1);
  endproperty
  a_ntc_wait: assert property (p_ntc_wait) else $error("Trip delay wrong");
  property p_vinf_wait;
    O_FLAG_SET.vinf |-> $past(hold_q[2], 2) == 16'(FLASH_CYC - 1);
  endproperty
  a_vinf_wait: assert property (p_vinf_wait) else $error("Flash deglitch wrong");
  property p_vin_en;
    O_FLAG_SET.vin |-> $past(I_VIN_MON_EN, 2);
  endproperty
  a_vin_en: assert property (p_vin_en) else $error("Supply event while disabled");
  property p_torch_clr;
    (I_FLASH_DONE && I_HW_TORCH_EN) |=> O_TORCH_BIT_CLR;
  endproperty
  a_torch_clr: assert property (p_torch_clr) else $error("Torch bit not cleared");
  property p_cov_armed;
    b_st_q == fdg_pkg::FDG_ST_ARMED;
  endproperty
  c_cov_armed: cover property (p_cov_armed);
  property p_cov_int;
    b_int && I_INT_REQ;
  endproperty
  c_cov_int: cover property (p_cov_int);
  property p_cov_vinf;
    O_FLAG_SET.vinf;
  endproperty
  c_cov_vinf: cover property (p_cov_vinf);

endmodule // fdg_flash_gpio_top

`default_nettype wire

//--- design/fdg_consts.svh
// Purpose: Constants for the flash driver pin function and capture block
// Assumes: 200 MHz core clock
// Notes: Offsets, field positions, reset values and timing counts
`ifndef FDG_CONSTS_SVH
`define FDG_CONSTS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define FDG_OFS_PIN_FUNC 8'h20
`define FDG_OFS_CAP_LVL 8'h21
`define FDG_PIN_FUNC_RST 8'h00
`define FDG_CAP_RST 8'h00

// ----------------------------------------
// Pin function fields
// ----------------------------------------
`define FDG_B_A_CTRL 0
`define FDG_B_A_DIR 1
`define FDG_B_A_DATA 2
`define FDG_B_B_CTRL 3
`define FDG_B_B_DIR 4
`define FDG_B_B_DATA 5
`define FDG_B_INT_EN 6

// ----------------------------------------
// Timing
// ----------------------------------------
`define FDG_CLK_MHZ 200
`define FDG_TRIP_US 250
`define FDG_FLASH_US 8
`define FDG_TRIP_CYC (`FDG_TRIP_US * `FDG_CLK_MHZ)
`define FDG_FLASH_CYC (`FDG_FLASH_US * `FDG_CLK_MHZ)

`endif

//--- design/fdg_pkg.sv
// Purpose: Types for the flash driver pin function and capture block
// Assumes: Nothing
// Notes: Field order matches the register bit order
package fdg_pkg;

  typedef struct packed {
    logic spare;
    logic int_en;
    logic b_data;
    logic b_dir;
    logic b_ctrl;
    logic a_data;
    logic a_dir;
    logic a_ctrl;
  } fdg_pin_func_t;

  typedef struct packed {
    logic vinf;
    logic vin;
    logic ntc;
  } fdg_evt_t;

  typedef struct packed {
    logic [3:0] led_b;
    logic [3:0] led_a;
  } fdg_code_t;

  typedef enum logic [2:0] {
    FDG_ST_FREE = 3'b001,
    FDG_ST_HALF = 3'b010,
    FDG_ST_ARMED = 3'b100
  } fdg_setup_t;

endpackage

//--- design/fdg_sync.sv
// Purpose: Two-stage synchroniser for pin and comparator levels
// Assumes: Inputs are asynchronous levels
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none

module fdg_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // fdg_sync

`default_nettype wire

//--- design/fdg_dly.sv
// Purpose: Qualify a level held for N cycles, emit one pulse
// Assumes: Input is already synchronous
// Notes: Pulse appears N cycles after the level first rises
`timescale 1ns/100ps
`default_nettype none

module fdg_dly #(
  parameter int N = 1600
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_lvl,
  output logic o_pulse
);

  localparam int CW = $clog2(N + 1);
  localparam logic [CW-1:0] LAST = CW'(N - 1);

  logic [CW-1:0] cnt_q;
  logic fired_q;
  logic pulse_q;
  wire hit = i_lvl && !fired_q && (cnt_q == LAST);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q <= (i_lvl && cnt_q != LAST) ? cnt_q + 1'b1 : (i_lvl ? cnt_q : '0);
      fired_q <= i_lvl && (fired_q || hit);
      pulse_q <= hit;
    end
  end

  assign o_pulse = pulse_q;

endmodule // fdg_dly

`default_nettype wire

//--- dv/fdg_host_model.sv
// Purpose: Host model issuing register strobes to the block
// Assumes: Strobes change at the falling clock edge
// Notes: Released address and data lines show the inverse value
`timescale 1ns/100ps
`default_nettype none

module fdg_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  // --------------------------------
  // Idle levels
  // --------------------------------
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'hff;
    o_wdata = 8'hff;
  end

  // --------------------------------
  // Bus cycles
  // --------------------------------
  // Same byte written n times back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    repeat (n) @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask

  // Read, answer taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule // fdg_host_model
`default_nettype wire

//--- dv/fdg_flash_gpio_top_tb.sv
// Purpose: Self-checking bench for pin function and capture block
// Assumes: Shortened qualify counts of 20 and 8 cycles
// Notes: Inputs change at the falling edge
`timescale 1ns/100ps
`default_nettype none

module fdg_flash_gpio_top_tb;
  `define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin \
    $display("MISMATCH %s exp %h got %h", nm, e, a); n_fail++; end end
  localparam int TRIP = 20;
  localparam int FLSH = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr, rd, pa, pb, irq, torch, fdone;
  logic [7:0] addr, wd, rdat, d;
  logic rv, v;
  logic a_out, a_oe_n, b_out, b_oe_n, tx1, tlvl, tx2, tclr;
  logic [2:0] en = 3'b000;
  logic [2:0] blw = 3'b000;
  logic [3:0] ca = 4'h0;
  logic [3:0] cb = 4'h0;
  fdg_pkg::fdg_evt_t flg;
  int n_fail = 0;
  int total_checks = 0;
  int cnt;

  always #2.5 clk = ~clk;

  initial begin
    pa = 1'b0;
    pb = 1'b0;
    irq = 1'b0;
    torch = 1'b0;
    fdone = 1'b0;
  end

  fdg_flash_gpio_top #(.TRIP_CYC(TRIP), .FLASH_CYC(FLSH)) i_fdg_flash_gpio_top (
    .I_CORE_CLK(clk), .I_NRST(rst_n), .I_REG_WR(wr), .I_REG_RD(rd),
    .I_REG_ADDR(addr), .I_REG_WDATA(wd), .O_REG_RDATA(rdat), .O_REG_RVALID(rv),
    .I_PIN_A_IN(pa), .O_PIN_A_OUT(a_out), .O_PIN_A_OE_N(a_oe_n),
    .I_PIN_B_IN(pb), .O_PIN_B_OUT(b_out), .O_PIN_B_OE_N(b_oe_n),
    .I_INT_REQ(irq), .I_HW_TORCH_EN(torch), .I_FLASH_DONE(fdone),
    .O_TX1_LVL(tx1), .O_TORCH_LVL(tlvl), .O_TX2_LVL(tx2), .O_TORCH_BIT_CLR(tclr),
    .I_NTC_EN(en[0]), .I_VIN_MON_EN(en[1]), .I_SUPPLY_FLASH_THRESHOLD_EN(en[2]),
    .I_NTC_BELOW(blw[0]), .I_VIN_BELOW(blw[1]), .I_SUPPLY_FLASH_THRESHOLD_BELOW(blw[2]),
    .I_LED_A_CODE(ca), .I_LED_B_CODE(cb), .O_FLAG_SET(flg));

  fdg_host_model i_fdg_host_model (.i_clk(clk), .i_rdata(rdat), .i_rvalid(rv),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wd));

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_fdg_host_model.rd(a, d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", e, d)
  endtask

  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_reset();
    `CHK("oe_a", 1'b1, a_oe_n)
    `CHK("oe_b", 1'b1, b_oe_n)
    rchk(8'h20, 8'h00);
    rchk(8'h21, 8'h00);
    rchk(8'h22, 8'h00);
  endtask

  task automatic t_outputs();
    i_fdg_host_model.wr(8'h20, 8'h1f, 1);
    settle();
    `CHK("oe_a one write", 1'b1, a_oe_n)
    `CHK("oe_b one write", 1'b1, b_oe_n)
    i_fdg_host_model.wr(8'h20, 8'h1f, 2);
    settle();
    `CHK("oe_a", 1'b0, a_oe_n)
    `CHK("out_a", 1'b1, a_out)
    `CHK("oe_b", 1'b0, b_oe_n)
    `CHK("out_b", 1'b0, b_out)
    i_fdg_host_model.wr(8'h20, 8'h3b, 1);
    settle();
    `CHK("out_a single", 1'b0, a_out)
    `CHK("out_b single", 1'b1, b_out)
    `CHK("oe_b single", 1'b0, b_oe_n)
  endtask

  task automatic t_inputs();
    pb = 1'b0;
    settle();
    i_fdg_host_model.wr(8'h20, 8'h88, 2);
    settle();
    `CHK("oe_b input", 1'b1, b_oe_n)
    rchk(8'h20, 8'h08);
    pb = 1'b1;
    settle();
    rchk(8'h20, 8'h08);
    i_fdg_host_model.wr(8'h20, 8'h88, 1);
    rchk(8'h20, 8'h28);
    pa = 1'b1;
    settle();
    i_fdg_host_model.wr(8'h20, 8'h89, 1);
    rchk(8'h20, 8'h2d);
    `CHK("oe_a input", 1'b1, a_oe_n)
    pa = 1'b0;
  endtask

  task automatic t_interrupt();
    i_fdg_host_model.wr(8'h20, 8'hf8, 2);
    settle();
    `CHK("int idle", 1'b1, b_oe_n)
    irq = 1'b1;
    settle();
    `CHK("int oe", 1'b0, b_oe_n)
    `CHK("int out", 1'b0, b_out)
    irq = 1'b0;
    settle();
    `CHK("int release", 1'b1, b_oe_n)
    i_fdg_host_model.wr(8'h20, 8'hb8, 1);
    irq = 1'b1;
    settle();
    `CHK("int off", 1'b1, b_out)
    `CHK("int off oe", 1'b0, b_oe_n)
    irq = 1'b0;
  endtask

  task automatic t_torch();
    i_fdg_host_model.wr(8'h20, 8'h00, 1);
    torch = 1'b1;
    pa = 1'b1;
    settle();
    `CHK("torch lvl", 1'b1, tlvl)
    `CHK("tx1 off", 1'b0, tx1)
    `CHK("tx2 lvl", 1'b1, tx2)
    pa = 1'b0;
    settle();
    `CHK("torch low", 1'b0, tlvl)
    fdone = 1'b1;
    @(negedge clk);
    fdone = 1'b0;
    `CHK("torch clr", 1'b1, tclr)
    torch = 1'b0;
    pa = 1'b1;
    settle();
    `CHK("clr pulse", 1'b0, tclr)
    `CHK("tx1 lvl", 1'b1, tx1)
    `CHK("torch off", 1'b0, tlvl)
    pa = 1'b0;
    settle();
  endtask

  // One event kind per pass, first disabled, then enabled
  task automatic t_capture();
    int n;
    for (int e = 0; e < 3; e++) begin
      n = (e == 2) ? FLSH : TRIP;
      ca = 4'(e + 3);
      cb = 4'(15 - e);
      blw = 3'(1 << e);
      cnt = 0;
      repeat (n + 10) begin
        @(negedge clk);
        if (flg[e] === 1'b1) cnt++;
      end
      `CHK("no flag disabled", 0, cnt)
      blw = 3'b000;
      settle();
      en = 3'(1 << e);
      @(negedge clk);
      blw = 3'(1 << e);
      cnt = 0;
      while (flg[e] !== 1'b1 && cnt < 60) begin
        @(posedge clk);
        #1;
        cnt++;
      end
      `CHK("flag lat", 1'b1, (cnt >= n + 2 && cnt <= n + 4))
      `CHK("other flags", 3'(1 << e), flg)
      rchk(8'h21, {cb, ca});
      blw = 3'b000;
      en = 3'b000;
      ca = 4'h0;
      settle();
      rchk(8'h21, {cb, 4'(e + 3)});
    end
  endtask

  // --------------------------------
  // Sequence and verdict
  // --------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #50000;
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_outputs();
    t_inputs();
    t_interrupt();
    t_torch();
    t_capture();
    wrap_up();
  end
endmodule // fdg_flash_gpio_top_tb
`default_nettype wire
